// File: rtl/sdp_pkg.sv
package sdp_pkg;

    // ****************************************
    // Geometry
    // ****************************************
    localparam int SDP_TOTAL_BITS_PLAIN  = 4096;
    localparam int SDP_TOTAL_BITS_PARITY = 4608;
    localparam int SDP_MAX_ADDR_W        = 12;
    localparam int SDP_MAX_DATA_W        = 36;

    // ****************************************
    // Clocking schemes
    // ****************************************
    typedef enum logic [1:0] {
        SDP_CLK_RW = 2'h1,
        SDP_CLK_IO = 2'h2
    } sdp_clk_mode_t;

    // ****************************************
    // Request carriers
    // ****************************************
    typedef struct packed {
        logic                      en;
        logic                      hold;
        logic [SDP_MAX_ADDR_W-1:0] addr;
        logic [SDP_MAX_DATA_W-1:0] data;
    } sdp_wr_req_t;

    typedef struct packed {
        logic                      en;
        logic                      hold;
        logic [SDP_MAX_ADDR_W-1:0] addr;
    } sdp_rd_req_t;

    // Shape is legal when both widths are plain widths or both are parity widths
    function automatic logic sdp_is_parity(input int w);
        return (w == 9) || (w == 18) || (w == 36);
    endfunction : sdp_is_parity

    function automatic logic sdp_is_plain(input int w);
        return (w == 1) || (w == 2) || (w == 4) || (w == 8) || (w == 16) || (w == 32);
    endfunction : sdp_is_plain

endpackage : sdp_pkg

// File: rtl/sdp_mem.sv
`timescale 1ns/1ps
`default_nettype none
// Bit-addressed storage; write of WR_W bits, registered read of RD_W bits
module sdp_mem #(
    parameter int TOTAL = 4096,
    parameter int WR_W  = 1,
    parameter int RD_W  = 1,
    parameter int WA_W  = 12,
    parameter int RA_W  = 12
) (
    input  wire logic            wclk,
    input  wire logic            we,
    input  wire logic [WA_W-1:0] waddr,
    input  wire logic [WR_W-1:0] wdata,
    input  wire logic            rclk,
    input  wire logic            re,
    input  wire logic [RA_W-1:0] raddr,
    output var  logic [RD_W-1:0] rdata
);
    logic [TOTAL-1:0] bits_q;
    logic [RD_W-1:0]  rdata_q;

    always_ff @(posedge wclk) begin
        if (we) begin
            bits_q[waddr*WR_W +: WR_W] <= wdata;
        end
    end

    // Old contents on same-address collision: read samples pre-write array
    always_ff @(posedge rclk) begin
        if (re) begin
            rdata_q <= bits_q[raddr*RD_W +: RD_W];
        end
    end

    assign rdata = rdata_q;
endmodule : sdp_mem
`default_nettype wire

// File: rtl/sdp_ram.sv
`timescale 1ns/1ps
`default_nettype none
module sdp_ram
    import sdp_pkg::*;
#(
    parameter int            WR_W     = 8,
    parameter int            RD_W     = 8,
    parameter sdp_clk_mode_t CLK_MODE = SDP_CLK_RW,
    parameter int            TOTAL    = sdp_is_parity(WR_W) ? SDP_TOTAL_BITS_PARITY
                                                            : SDP_TOTAL_BITS_PLAIN,
    parameter int            WA_W     = $clog2(TOTAL / WR_W),
    parameter int            RA_W     = $clog2(TOTAL / RD_W)
) (
    input  wire logic            clk_sys,
    input  wire logic            rst_n,
    input  wire logic            clk_a,
    input  wire logic            clk_b,
    input  wire logic            wr_en,
    input  wire logic            wr_addr_hold,
    input  wire logic [WA_W-1:0] wr_addr,
    input  wire logic [WR_W-1:0] wr_data,
    input  wire logic            rd_en,
    input  wire logic            rd_addr_hold,
    input  wire logic [RA_W-1:0] rd_addr,
    output var  logic [RD_W-1:0] rd_data
);
    import sdp_pkg::*;

    // ****************************************
    // Port geometry
    // ****************************************
    localparam int WR_DEPTH = TOTAL / WR_W;
    localparam int RD_DEPTH = TOTAL / RD_W;
    localparam bit PAIR_OK  = (sdp_is_plain(WR_W) && sdp_is_plain(RD_W)) ||
                              (sdp_is_parity(WR_W) && sdp_is_parity(RD_W));

    // ****************************************
    // Shape checks
    // ****************************************
    // plain with plain, parity with parity
    if (!PAIR_OK) begin : g_bad_shape
        $error("Read and write widths cannot be paired");
    end

    if ((WA_W != $clog2(WR_DEPTH)) || (RA_W != $clog2(RD_DEPTH))) begin : g_bad_addr
        $error("Address width does not match port depth");
    end

    // Both ports cover the whole array
    if ((WR_DEPTH * WR_W != TOTAL) || (RD_DEPTH * RD_W != TOTAL)) begin : g_bad_fill
        $error("Port shape does not fill the array");
    end

    // ****************************************
    // Check qualifier
    // ****************************************
    // Reset gates the checks only, never the datapath
    logic live_q;
    logic live_d;
    logic chk_off;

    always_comb begin
        live_d = rst_n;
    end

    always_ff @(posedge clk_sys) begin
        live_q <= live_d;
    end

    // Checks wake one cycle after reset leaves
    assign chk_off = !rst_n || !live_q;

    // ****************************************
    // Clock selection
    // ****************************************
    // RW mode: a=write, b=read. IO mode: a=input regs, b=output regs
    logic wclk;
    logic rin_clk;
    logic rout_clk;

    assign wclk     = clk_a;
    assign rin_clk  = (CLK_MODE == SDP_CLK_RW) ? clk_b : clk_a;
    assign rout_clk = clk_b;

    // ****************************************
    // Write input registers
    // ****************************************
    logic [WA_W-1:0] wa_q;
    logic [WA_W-1:0] wa_d;
    logic [WR_W-1:0] wd_q;
    logic [WR_W-1:0] wd_d;
    logic            we_q;
    logic            we_d;

    always_comb begin
        wa_d = wr_addr_hold ? wa_q : wr_addr;
        wd_d = wr_data;
        we_d = wr_en;
    end

    always_ff @(posedge wclk) begin
        wa_q <= wa_d;
        wd_q <= wd_d;
        we_q <= we_d;
    end

    // ****************************************
    // Read input registers
    // ****************************************
    logic [RA_W-1:0] ra_q;
    logic [RA_W-1:0] ra_d;
    logic            re_q;
    logic            re_d;

    always_comb begin
        ra_d = rd_addr_hold ? ra_q : rd_addr;
        re_d = rd_en;
    end

    always_ff @(posedge rin_clk) begin
        ra_q <= ra_d;
        re_q <= re_d;
    end

    // ****************************************
    // Storage
    // ****************************************
    logic [RD_W-1:0] mem_rd;

    // old data on collision
    // Array read on the read input clock, before that edge's write lands
    sdp_mem #(
        .TOTAL (TOTAL),
        .WR_W  (WR_W),
        .RD_W  (RD_W),
        .WA_W  (WA_W),
        .RA_W  (RA_W)
    ) u_mem (
        .wclk  (wclk),
        .we    (we_q),
        .waddr (wa_q),
        .wdata (wd_q),
        .rclk  (rin_clk),
        .re    (re_q),
        .raddr (ra_q),
        .rdata (mem_rd)
    );

    // ****************************************
    // Output register
    // ****************************************
    logic            rvalid_q;
    logic            rvalid_d;
    logic [RD_W-1:0] rd_q;
    logic [RD_W-1:0] rd_d;

    // Marks the cycle in which the array word is fresh
    always_comb begin
        rvalid_d = re_q;
        // output updates only after an enabled read
        rd_d     = rvalid_q ? mem_rd : rd_q;
    end

    always_ff @(posedge rout_clk) begin
        rvalid_q <= rvalid_d;
        rd_q     <= rd_d;
    end

    assign rd_data = rd_q;

    // ****************************************
    // Write side checks
    // ****************************************
    sequence s_wr_hold;
        wr_addr_hold;
    endsequence

    sequence s_wr_capture;
        !wr_addr_hold;
    endsequence

    AST_HOLD_WADDR: assert property (@(posedge wclk) disable iff (chk_off)
        s_wr_hold |=> (wa_q == $past(wa_q)))
        else $error("write address changed under hold");

    AST_CAPTURE_WADDR: assert property (@(posedge wclk) disable iff (chk_off)
        s_wr_capture |=> (wa_q == $past(wr_addr)))
        else $error("write address not captured");

    // Capture resumes the cycle after hold drops
    AST_RESUME_WADDR: assert property (@(posedge wclk) disable iff (chk_off)
        s_wr_hold ##1 s_wr_capture |=> (wa_q == $past(wr_addr)))
        else $error("write address did not resume after hold");

    AST_WE_REG: assert property (@(posedge wclk) disable iff (chk_off)
        1'b1 |=> (we_q == $past(wr_en)))
        else $error("write enable not registered");

    AST_WDATA_REG: assert property (@(posedge wclk) disable iff (chk_off)
        1'b1 |=> (wd_q == $past(wr_data)))
        else $error("write data not registered");

    // Array word after an enabled write
    AST_WR_LANDS: assert property (@(posedge wclk) disable iff (chk_off)
        we_q |=> (u_mem.bits_q[$past(wa_q) * WR_W +: WR_W] == $past(wd_q)))
        else $error("write did not land in the array");

    // Enable keeps loading while reset is low
    AST_WE_NO_CLEAR: assert property (@(posedge wclk)
        !rst_n |=> (we_q == $past(wr_en)))
        else $error("write enable cleared by reset");

    // ****************************************
    // Read side checks
    // ****************************************
    sequence s_rd_hold;
        rd_addr_hold;
    endsequence

    sequence s_rd_capture;
        !rd_addr_hold;
    endsequence

    AST_HOLD_RADDR: assert property (@(posedge rin_clk) disable iff (chk_off)
        s_rd_hold |=> (ra_q == $past(ra_q)))
        else $error("read address changed under hold");

    AST_CAPTURE_RADDR: assert property (@(posedge rin_clk) disable iff (chk_off)
        s_rd_capture |=> (ra_q == $past(rd_addr)))
        else $error("read address not captured");

    // Capture resumes the cycle after hold drops
    AST_RESUME_RADDR: assert property (@(posedge rin_clk) disable iff (chk_off)
        s_rd_hold ##1 s_rd_capture |=> (ra_q == $past(rd_addr)))
        else $error("read address did not resume after hold");

    AST_RE_REG: assert property (@(posedge rin_clk) disable iff (chk_off)
        1'b1 |=> (re_q == $past(rd_en)))
        else $error("read enable not registered");

    // Enable keeps loading while reset is low
    AST_RE_NO_CLEAR: assert property (@(posedge rin_clk)
        !rst_n |=> (re_q == $past(rd_en)))
        else $error("read enable cleared by reset");

    // Read returns the word as it stood before this edge's write
    AST_RD_OLD_DATA: assert property (@(posedge rin_clk) disable iff (chk_off)
        re_q |=> (mem_rd == $past(u_mem.bits_q[ra_q * RD_W +: RD_W])))
        else $error("read did not return old contents");

    // ****************************************
    // Output checks
    // ****************************************
    sequence s_idle_read;
        !re_q ##1 !rvalid_q;
    endsequence

    sequence s_read_issue;
        re_q ##1 rvalid_q;
    endsequence

    AST_RVALID: assert property (@(posedge rout_clk) disable iff (chk_off)
        1'b1 |=> (rvalid_q == $past(re_q)))
        else $error("read valid does not follow read enable");

    AST_RD_UPDATE: assert property (@(posedge rout_clk) disable iff (chk_off)
        rvalid_q |=> (rd_q == $past(mem_rd)))
        else $error("read data not updated after read");

    // Output end of the read pipeline: after re_q then rvalid_q, rd_data takes mem_rd
    AST_RD_PIPE: assert property (@(posedge rout_clk) disable iff (chk_off)
        s_read_issue |=> (rd_data == $past(mem_rd)))
        else $error("read pipeline lost the word");

    AST_RD_STABLE: assert property (@(posedge rout_clk) disable iff (chk_off)
        s_idle_read |=> $stable(rd_q))
        else $error("read data changed while disabled");
endmodule : sdp_ram
`default_nettype wire

// File: testbench/sdp_user.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Fabric user logic
// ****
module sdp_user #(
    parameter int AW = 9,
    parameter int DW = 8
) (
    input  wire logic          clk,
    output var  logic          wr_en,
    output var  logic          wr_addr_hold,
    output var  logic [AW-1:0] wr_addr,
    output var  logic [DW-1:0] wr_data,
    output var  logic          rd_en,
    output var  logic          rd_addr_hold,
    output var  logic [AW-1:0] rd_addr
);
    initial begin
        {wr_en, wr_addr_hold, rd_en, rd_addr_hold} = 4'h0;
        wr_addr = '0;
        wr_data = '0;
        rd_addr = '0;
    end
    task automatic op(input logic we, re, hw, hr, input logic [AW-1:0] wa, ra,
                      input logic [DW-1:0] d);
        @(posedge clk);
        wr_en        <= we;
        rd_en        <= re;
        wr_addr_hold <= hw;
        rd_addr_hold <= hr;
        wr_addr      <= wa;
        rd_addr      <= ra;
        wr_data      <= d;
    endtask : op
    task automatic rel();
        op(1'b0, 1'b0, 1'b0, 1'b0, ~wr_addr, ~rd_addr, ~wr_data);
    endtask : rel
endmodule : sdp_user
`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sdp_pkg::*;
    logic       clk_sys, rst_n, wr_en, wr_addr_hold, rd_en, rd_addr_hold;
    logic [8:0] wr_addr, rd_addr;
    logic [7:0] wr_data, rd_data, rd_data_io;
    int         errors, checks;
    logic [8:0] ta [4] = '{9'h000, 9'h001, 9'h0ff, 9'h1ff};
    logic [7:0] td [4] = '{8'ha5, 8'h3c, 8'h96, 8'h0f};
    always #5 clk_sys = ~clk_sys;
    sdp_ram #(.WR_W(8), .RD_W(8)) sdp_ram_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .clk_a(clk_sys), .clk_b(clk_sys),
        .wr_en(wr_en), .wr_addr_hold(wr_addr_hold), .wr_addr(wr_addr),
        .wr_data(wr_data), .rd_en(rd_en), .rd_addr_hold(rd_addr_hold),
        .rd_addr(rd_addr), .rd_data(rd_data));
    sdp_ram #(.WR_W(8), .RD_W(8), .CLK_MODE(SDP_CLK_IO)) sdp_ram_io_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .clk_a(clk_sys), .clk_b(clk_sys),
        .wr_en(wr_en), .wr_addr_hold(wr_addr_hold), .wr_addr(wr_addr),
        .wr_data(wr_data), .rd_en(rd_en), .rd_addr_hold(rd_addr_hold),
        .rd_addr(rd_addr), .rd_data(rd_data_io));
    sdp_user #(.AW(9), .DW(8)) sdp_user_inst (
        .clk(clk_sys), .wr_en(wr_en), .wr_addr_hold(wr_addr_hold), .wr_addr(wr_addr),
        .wr_data(wr_data), .rd_en(rd_en), .rd_addr_hold(rd_addr_hold), .rd_addr(rd_addr));
    task automatic chk(input string n, input logic [7:0] e, g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        sdp_user_inst.op(1'b1, 1'b0, 1'b0, 1'b0, a, ~a, d);
        sdp_user_inst.rel();
    endtask : wr
    task automatic settle(input logic [7:0] e);
        sdp_user_inst.rel();
        repeat (5) @(posedge clk_sys);
        #1 chk("rd_data", e, rd_data);
        chk("rd_data_io", e, rd_data_io);
    endtask : settle
    task automatic rd(input logic [8:0] a, input logic [7:0] e);
        sdp_user_inst.op(1'b0, 1'b1, 1'b0, 1'b0, ~a, a, 8'h00);
        settle(e);
    endtask : rd
    task automatic stop_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    initial begin
        #200us;
        errors++;
        stop_test();
    end
    initial begin
        clk_sys = 1'b0;
        rst_n = 1'b0;
        errors = 0;
        checks = 0;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) wr(ta[i], td[i]);
        for (int i = 0; i < 4; i++) rd(ta[i], td[i]);
        $display("test write_read done");
        for (int i = 0; i < 3; i++) begin
            sdp_user_inst.op(1'b0, 1'b0, 1'b0, 1'b0, 9'h000, ta[i], 8'h00);
            #1 chk("rd_data", td[3], rd_data);
            chk("rd_data_io", td[3], rd_data_io);
        end
        $display("test read_hold_output done");
        sdp_user_inst.op(1'b1, 1'b1, 1'b0, 1'b0, 9'h0ff, 9'h0ff, 8'h77);
        settle(td[2]);
        rd(9'h0ff, 8'h77);
        $display("test collision done");
        wr(9'h011, 8'h11);
        sdp_user_inst.op(1'b0, 1'b0, 1'b0, 1'b0, 9'h010, 9'h000, 8'h00);
        sdp_user_inst.op(1'b1, 1'b0, 1'b1, 1'b0, 9'h011, 9'h000, 8'h5a);
        sdp_user_inst.rel();
        rd(9'h010, 8'h5a);
        rd(9'h011, 8'h11);
        sdp_user_inst.op(1'b0, 1'b0, 1'b0, 1'b0, 9'h000, 9'h010, 8'h00);
        sdp_user_inst.op(1'b0, 1'b1, 1'b0, 1'b1, 9'h000, 9'h000, 8'h00);
        settle(8'h5a);
        rd(9'h000, td[0]);
        $display("test address_hold done");
        stop_test();
    end
endmodule : tb
`default_nettype wire
